/* File: logic/prca_cmod.sv */
// Purpose: One capture/compare module with its I/O line
// Assumes: Counter value and step strobe from the array core
// Notes:   Holds its own mode and compare registers
`timescale 1ns/1ns
module prca_cmod (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] count,
    input wire logic stepped,
    input wire logic wrMode,
    input wire logic wrLow,
    input wire logic wrHigh,
    input wire logic [7:0] wrData,
    input wire logic wdtOn,
    input wire logic ioIn,
    output logic [7:0] modeVal,
    output logic [15:0] cmpVal,
    output logic eventHit,
    output logic wdtHit,
    output logic ioOut,
    output logic ioDriveN
);
    logic [7:0] mode_reg;
    logic [7:0] cmpLow_reg;
    logic [7:0] cmpHigh_reg;
    logic out_reg;
    logic hsoPrev_reg;
    logic inLast_reg;
    logic inStable_reg;
    logic comp, rise, fall, mat, tog, pwm, wide;
    logic capMode, swMode, hsoMode, freqMode, pwm8Mode, pwm16Mode;
    logic fullEq, lowEq, lowWrap, fullWrap, edgeOk, capHit;

    assign comp = mode_reg[prca_pkg::MM_COMP];
    assign rise = mode_reg[prca_pkg::MM_RISE];
    assign fall = mode_reg[prca_pkg::MM_FALL];
    assign mat = mode_reg[prca_pkg::MM_MATCH];
    assign tog = mode_reg[prca_pkg::MM_TOG];
    assign pwm = mode_reg[prca_pkg::MM_PWM];
    assign wide = mode_reg[prca_pkg::MM_WIDE];
    // -----------------------------------------------------------------
    // Mode decode
    // -----------------------------------------------------------------
    assign capMode = !wdtOn && !mat && !tog && !pwm && (rise || fall);
    assign swMode = wdtOn || (comp && mat && !tog);
    assign hsoMode = !wdtOn && comp && mat && tog;
    assign freqMode = !wdtOn && comp && tog && pwm && !mat;
    assign pwm8Mode = !wdtOn && comp && pwm && !tog && !mat && !wide;
    assign pwm16Mode = !wdtOn && comp && pwm && !tog && !mat && wide;
    assign fullEq = stepped && (count == {cmpHigh_reg, cmpLow_reg});
    assign lowEq = stepped && (count[7:0] == cmpLow_reg);
    assign lowWrap = stepped && (count[7:0] == 8'h00);
    assign fullWrap = stepped && (count == 16'h0000);
    // -----------------------------------------------------------------
    // Input filter: a level counts only once seen twice in a row
    // -----------------------------------------------------------------
    assign edgeOk = (ioIn == inLast_reg) && (inLast_reg != inStable_reg);
    assign capHit = capMode && edgeOk && ((inLast_reg && rise) || (!inLast_reg && fall));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            inLast_reg <= 1'b0;
            inStable_reg <= 1'b0;
        end else begin
            inLast_reg <= ioIn;
            if (edgeOk) begin
                inStable_reg <= inLast_reg;
            end
        end
    end
    // -----------------------------------------------------------------
    // Mode and compare registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= prca_pkg::MMODE_RST;
        end else if (wrMode) begin
            mode_reg <= wrData;
        end else if (wrLow) begin
            mode_reg[prca_pkg::MM_COMP] <= 1'b0;
        end else if (wrHigh) begin
            mode_reg[prca_pkg::MM_COMP] <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmpLow_reg <= 8'h00;
            cmpHigh_reg <= 8'h00;
        end else if (wrLow) begin
            cmpLow_reg <= wrData;
        end else if (wrHigh) begin
            // Watchdog reload ignores the written value
            cmpHigh_reg <= wdtOn ? count[15:8] + cmpLow_reg : wrData;
        end else if (capHit) begin
            {cmpHigh_reg, cmpLow_reg} <= count;
        end else if (freqMode && lowEq) begin
            cmpLow_reg <= cmpLow_reg + cmpHigh_reg;
        end else if (pwm8Mode && lowWrap) begin
            cmpLow_reg <= count[15:8];
        end
    end
    // -----------------------------------------------------------------
    // Output line
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_reg <= 1'b1;
            hsoPrev_reg <= 1'b0;
        end else begin
            hsoPrev_reg <= hsoMode;
            if (hsoMode && !hsoPrev_reg) begin
                out_reg <= 1'b1;
            end else if ((hsoMode && fullEq) || (freqMode && lowEq)) begin
                out_reg <= !out_reg;
            end else if (pwm8Mode && lowEq) begin
                out_reg <= 1'b1;
            end else if (pwm8Mode && lowWrap) begin
                out_reg <= 1'b0;
            end else if (pwm16Mode && fullEq) begin
                out_reg <= 1'b1;
            end else if (pwm16Mode && fullWrap) begin
                out_reg <= 1'b0;
            end else if (!comp && pwm && !tog) begin
                out_reg <= 1'b0;
            end
        end
    end

    assign modeVal = mode_reg;
    assign cmpVal = {cmpHigh_reg, cmpLow_reg};
    assign eventHit = capHit || (!wdtOn && fullEq && (swMode || hsoMode || pwm16Mode));
    assign wdtHit = wdtOn && lowWrap && (count[15:8] == cmpHigh_reg);
    assign ioOut = out_reg;
    assign ioDriveN = !(!wdtOn && comp && (tog || pwm));
endmodule

/* File: logic/prca_pkg.sv */
// Purpose: Shared constants for the counter array
// Assumes: 8-bit register port, six modules
// Notes:   Offsets are word indices on the plain port
package prca_pkg;
    localparam int ADDR_W = 6;
    localparam int MODS = 6;
    localparam int WDT_MOD = 5;
    // -----------------------------------------------------------------
    // Register offsets
    // -----------------------------------------------------------------
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_AMODE = 6'h01;
    localparam logic [5:0] OFF_CNTL = 6'h02;
    localparam logic [5:0] OFF_CNTH = 6'h03;
    localparam logic [5:0] OFF_MMODE = 6'h10;
    localparam logic [5:0] OFF_CMPL = 6'h18;
    localparam logic [5:0] OFF_CMPH = 6'h20;
    // -----------------------------------------------------------------
    // Control register fields
    // -----------------------------------------------------------------
    localparam int CT_OVF = 7;
    localparam int CT_RUN = 6;
    // -----------------------------------------------------------------
    // Array mode register fields
    // -----------------------------------------------------------------
    localparam int AM_IDLE = 7;
    localparam int AM_WDT = 6;
    localparam int AM_TB_LO = 1;
    localparam int AM_OVFIE = 0;
    localparam logic [7:0] AMODE_RST = 8'h40;
    // -----------------------------------------------------------------
    // Module mode register fields
    // -----------------------------------------------------------------
    localparam int MM_WIDE = 7;
    localparam int MM_COMP = 6;
    localparam int MM_RISE = 5;
    localparam int MM_FALL = 4;
    localparam int MM_MATCH = 3;
    localparam int MM_TOG = 2;
    localparam int MM_PWM = 1;
    localparam int MM_IE = 0;
    localparam logic [7:0] MMODE_RST = 8'h00;
    // -----------------------------------------------------------------
    // Timing counts
    // -----------------------------------------------------------------
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [3:0] DIV4_LAST = 4'h3;
    localparam int STABLE_CYCLES = 2;
    typedef enum logic [2:0] {
        TB_DIV12 = 3'b000,
        TB_DIV4 = 3'b001,
        TB_T0OVF = 3'b010,
        TB_EXTIN = 3'b011,
        TB_SYS = 3'b100,
        TB_OSC8 = 3'b101,
        TB_RSV6 = 3'b110,
        TB_RSV7 = 3'b111
    } prca_tb_e;
endpackage

/* File: logic/prca_top.sv */
// Functional notes
// - One 16-bit counter, six independent modules
// - Three-bit select picks the counter timebase
// - External input counts on falling edges
// - Oscillator divide-by-eight resynchronized before use
// - Low byte read snapshots high byte
// - Counter reads never disturb counting
// - Wrap sets overflow flag, optional interrupt
// - Overflow flag cleared only by software
// - Keeps counting in idle unless suspended
// - Capture edge chosen by rise/fall bits
// - Capture loads counter, sets event flag
// - Input levels need two stable cycles
// - Compare match sets event flag, except in frequency, 8-bit PWM and watchdog modes
// - Event flags cleared only by software
// - Module enable lets flag raise interrupt
// - Toggle output on every match
// - Decode frequency, 8-bit, 16-bit PWM
// - Low write clears, high write sets comparator
// - Module 5 watchdog, on after reset
// - Toggle output starts and re-enters at one
//
// Purpose: Counter array core with register port
// Assumes: Inputs synchronous to clk except the oscillator tap
// Notes:   Read data appear one cycle after the read strobe
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ns
module prca_top #(
    parameter int MODS = prca_pkg::MODS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [prca_pkg::ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic cpuIdle,
    input wire logic timer0Ovf,
    input wire logic externalCountInput,
    input wire logic oscDiv8,
    input wire logic [MODS-1:0] moduleIoIn,
    output logic [MODS-1:0] moduleIoOut,
    output logic [MODS-1:0] moduleIoDriveN,
    output logic irqReq,
    output logic wdtResetReq
);
    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    logic [15:0] count_reg;
    logic [7:0] snapshot_reg;
    logic stepped_reg;
    logic [3:0] presc_reg;
    logic eciPrev_reg;
    logic oscSync1_reg;
    logic oscSync2_reg;
    logic oscSync3_reg;
    logic overflowFlag_reg;
    logic runEnable_reg;
    logic [MODS-1:0] eventFlag_reg;
    logic idleSuspend_reg;
    logic wdtEnable_reg;
    logic [2:0] timebase_reg;
    logic overflowIrqEnable_reg;
    logic [7:0] rdData_reg;
    logic irq_reg;
    logic wdtReset_reg;
    logic [MODS-1:0] ioOut_reg;
    logic [MODS-1:0] ioDriveN_reg;

    logic wrCtrl, wrAmode, wrCntL, wrCntH, rdCntL;
    logic [MODS-1:0] wrMode, wrLow, wrHigh;
    logic tick, running, advance;
    logic [3:0] prescLast;
    prca_pkg::prca_tb_e tbSel;
    logic [7:0] modeVal [MODS];
    logic [15:0] cmpVal [MODS];
    logic [MODS-1:0] eventHit;
    logic [MODS-1:0] wdtHit;
    logic [MODS-1:0] ioOutRaw;
    logic [MODS-1:0] ioDriveRaw;
    logic [MODS-1:0] modIrqEnable;
    logic [7:0] rdMux;
    logic wrapHit;

    // -----------------------------------------------------------------
    // Address decode
    // -----------------------------------------------------------------
    assign wrCtrl = regWr && (regAddr == prca_pkg::OFF_CTRL);
    assign wrAmode = regWr && (regAddr == prca_pkg::OFF_AMODE);
    // Counter bytes are write-protected while the watchdog runs
    assign wrCntL = regWr && (regAddr == prca_pkg::OFF_CNTL) && !wdtEnable_reg;
    assign wrCntH = regWr && (regAddr == prca_pkg::OFF_CNTH) && !wdtEnable_reg;
    assign rdCntL = regRd && (regAddr == prca_pkg::OFF_CNTL);

    always_comb begin
        for (int i = 0; i < MODS; i++) begin
            wrMode[i] = regWr && (regAddr == prca_pkg::OFF_MMODE + 6'(i))
                && !(wdtEnable_reg && i == prca_pkg::WDT_MOD);
            wrLow[i] = regWr && (regAddr == prca_pkg::OFF_CMPL + 6'(i));
            wrHigh[i] = regWr && (regAddr == prca_pkg::OFF_CMPH + 6'(i));
            modIrqEnable[i] = modeVal[i][prca_pkg::MM_IE];
        end
    end

    // -----------------------------------------------------------------
    // Timebase selection
    // -----------------------------------------------------------------
    assign tbSel = prca_pkg::prca_tb_e'(timebase_reg);
    assign prescLast = (tbSel == prca_pkg::TB_DIV4) ? prca_pkg::DIV4_LAST : prca_pkg::DIV12_LAST;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            presc_reg <= 4'h0;
        end else if (presc_reg >= prescLast) begin
            presc_reg <= 4'h0;
        end else begin
            presc_reg <= presc_reg + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            eciPrev_reg <= 1'b0;
        end else begin
            eciPrev_reg <= externalCountInput;
        end
    end

    // Oscillator tap is asynchronous: two flops, then edge detect
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oscSync1_reg <= 1'b0;
            oscSync2_reg <= 1'b0;
            oscSync3_reg <= 1'b0;
        end else begin
            oscSync1_reg <= oscDiv8;
            oscSync2_reg <= oscSync1_reg;
            oscSync3_reg <= oscSync2_reg;
        end
    end

    always_comb begin
        case (tbSel)
            prca_pkg::TB_DIV12: tick = (presc_reg == prca_pkg::DIV12_LAST);
            prca_pkg::TB_DIV4: tick = (presc_reg >= prca_pkg::DIV4_LAST);
            prca_pkg::TB_T0OVF: tick = timer0Ovf;
            prca_pkg::TB_EXTIN: tick = eciPrev_reg && !externalCountInput;
            prca_pkg::TB_SYS: tick = 1'b1;
            prca_pkg::TB_OSC8: tick = oscSync2_reg && !oscSync3_reg;
            default: tick = 1'b0;
        endcase
    end

    // -----------------------------------------------------------------
    // Counter
    // -----------------------------------------------------------------
    // Watchdog forces the counter on regardless of the run bit
    assign running = (runEnable_reg || wdtEnable_reg) && !(idleSuspend_reg && cpuIdle);
    assign advance = tick && running && !wrCntL && !wrCntH;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= 16'h0000;
        end else if (wrCntL) begin
            count_reg[7:0] <= regWrData;
        end else if (wrCntH) begin
            count_reg[15:8] <= regWrData;
        end else if (advance) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // Modules compare against the value just reached
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stepped_reg <= 1'b0;
        end else begin
            stepped_reg <= advance;
        end
    end

    assign wrapHit = stepped_reg && (count_reg == 16'h0000);

    // Snapshot only; the counter path never sees a read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            snapshot_reg <= 8'h00;
        end else if (rdCntL) begin
            snapshot_reg <= count_reg[15:8];
        end
    end

    // -----------------------------------------------------------------
    // Array mode register
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idleSuspend_reg <= prca_pkg::AMODE_RST[prca_pkg::AM_IDLE];
            wdtEnable_reg <= prca_pkg::AMODE_RST[prca_pkg::AM_WDT];
            timebase_reg <= prca_pkg::AMODE_RST[prca_pkg::AM_TB_LO +: 3];
            overflowIrqEnable_reg <= prca_pkg::AMODE_RST[prca_pkg::AM_OVFIE];
        end else if (wrAmode) begin
            wdtEnable_reg <= regWrData[prca_pkg::AM_WDT];
            overflowIrqEnable_reg <= regWrData[prca_pkg::AM_OVFIE];
            if (!wdtEnable_reg) begin
                // Clock source and idle control frozen under watchdog
                idleSuspend_reg <= regWrData[prca_pkg::AM_IDLE];
                timebase_reg <= regWrData[prca_pkg::AM_TB_LO +: 3];
            end
        end
    end

    // -----------------------------------------------------------------
    // Control register and flags
    // -----------------------------------------------------------------
    // Hardware set is OR-ed in last, so it wins over a clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            overflowFlag_reg <= 1'b0;
            runEnable_reg <= 1'b0;
            eventFlag_reg <= '0;
        end else begin
            if (wrCtrl) begin
                overflowFlag_reg <= regWrData[prca_pkg::CT_OVF] || wrapHit;
                runEnable_reg <= regWrData[prca_pkg::CT_RUN];
                eventFlag_reg <= regWrData[MODS-1:0] | eventHit;
            end else begin
                overflowFlag_reg <= overflowFlag_reg || wrapHit;
                eventFlag_reg <= eventFlag_reg | eventHit;
            end
        end
    end

    // -----------------------------------------------------------------
    // Interrupt request and watchdog reset
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (overflowFlag_reg && overflowIrqEnable_reg)
                || |(eventFlag_reg & modIrqEnable);
        end
    end

    // While the watchdog runs, writing one to the module 5 flag forces the reset too
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wdtReset_reg <= 1'b0;
        end else begin
            wdtReset_reg <= wdtHit[prca_pkg::WDT_MOD]
                || (wrCtrl && wdtEnable_reg && regWrData[prca_pkg::WDT_MOD]);
        end
    end

    // -----------------------------------------------------------------
    // Capture/compare modules
    // -----------------------------------------------------------------
    for (genvar g = 0; g < MODS; g++) begin : gMod
        prca_cmod uMod (
            .clk(clk),
            .nrst(nrst),
            .count(count_reg),
            .stepped(stepped_reg),
            .wrMode(wrMode[g]),
            .wrLow(wrLow[g]),
            .wrHigh(wrHigh[g]),
            .wrData(regWrData),
            .wdtOn(wdtEnable_reg && g == prca_pkg::WDT_MOD),
            .ioIn(moduleIoIn[g]),
            .modeVal(modeVal[g]),
            .cmpVal(cmpVal[g]),
            .eventHit(eventHit[g]),
            .wdtHit(wdtHit[g]),
            .ioOut(ioOutRaw[g]),
            .ioDriveN(ioDriveRaw[g])
        );
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ioOut_reg <= '1;
            ioDriveN_reg <= '1;
        end else begin
            ioOut_reg <= ioOutRaw;
            ioDriveN_reg <= ioDriveRaw;
        end
    end

    // -----------------------------------------------------------------
    // Read path
    // -----------------------------------------------------------------
    always_comb begin
        rdMux = 8'h00;
        if (regAddr == prca_pkg::OFF_CTRL) begin
            rdMux[prca_pkg::CT_OVF] = overflowFlag_reg;
            rdMux[prca_pkg::CT_RUN] = runEnable_reg;
            rdMux[MODS-1:0] = eventFlag_reg;
        end else if (regAddr == prca_pkg::OFF_AMODE) begin
            rdMux[prca_pkg::AM_IDLE] = idleSuspend_reg;
            rdMux[prca_pkg::AM_WDT] = wdtEnable_reg;
            rdMux[prca_pkg::AM_TB_LO +: 3] = timebase_reg;
            rdMux[prca_pkg::AM_OVFIE] = overflowIrqEnable_reg;
        end else if (regAddr == prca_pkg::OFF_CNTL) begin
            rdMux = count_reg[7:0];
        end else if (regAddr == prca_pkg::OFF_CNTH) begin
            rdMux = snapshot_reg;
        end else begin
            for (int i = 0; i < MODS; i++) begin
                if (regAddr == prca_pkg::OFF_MMODE + 6'(i)) begin
                    rdMux = modeVal[i];
                end
                if (regAddr == prca_pkg::OFF_CMPL + 6'(i)) begin
                    rdMux = cmpVal[i][7:0];
                end
                if (regAddr == prca_pkg::OFF_CMPH + 6'(i)) begin
                    rdMux = cmpVal[i][15:8];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdData_reg <= 8'h00;
        end else if (regRd) begin
            rdData_reg <= rdMux;
        end else begin
            rdData_reg <= 8'h00;
        end
    end

    assign regRdData = rdData_reg;
    assign irqReq = irq_reg;
    assign wdtResetReq = wdtReset_reg;
    assign moduleIoOut = ioOut_reg;
    assign moduleIoDriveN = ioDriveN_reg;
endmodule

/* File: testbench/prca_partner.sv */
// Purpose: Outside sources for module lines and count inputs
// Assumes: Bench sets line levels
// Notes:   Oscillator tap runs free, unrelated in phase
`timescale 1ns/1ns
module prca_partner (
    input wire logic clk,
    input wire logic [5:0] ioLevel,
    input wire logic glitch,
    output logic [5:0] ioLine,
    output logic extCount,
    output logic osc8,
    output logic t0Pulse
);
    logic [3:0] div = 4'h0;
    initial begin
        ioLine = 6'h00;
        extCount = 1'b0;
        osc8 = 1'b0;
        t0Pulse = 1'b0;
    end
    always #37 osc8 = ~osc8;
    always @(posedge clk) begin
        div <= div + 4'h1;
        extCount <= div[2];
        t0Pulse <= (div == 4'hf);
        ioLine <= glitch ? ~ioLevel : ioLevel;
    end
endmodule

/* File: testbench/prca_top_assertions.sv */
// Purpose: Port checks for the counter array
// Assumes: Bound to prca_top, latencies as handed over
// Notes:   Sees outputs and strobes only
`timescale 1ns/1ns
module prca_chk #(
    parameter int MODS = 6
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic [MODS-1:0] moduleIoOut,
    input wire logic [MODS-1:0] moduleIoDriveN,
    input wire logic irqReq,
    input wire logic wdtResetReq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == 8'h00) else $error("read data off slot");
    AST_IRQ_HOLD: assert property ($fell(irqReq) |-> $past(regWr) || $past(regWr, 2))
        else $error("irq fell without write");
    AST_IRQ_RISE: assert property ($rose(irqReq) && !regWr && !$past(regWr) |=> irqReq)
        else $error("irq dropped unasked");
    AST_RST_OUT: assert property ($rose(nrst) |-> moduleIoOut == '1 && moduleIoDriveN == '1)
        else $error("outputs not idle high");
    AST_RST_QUIET: assert property ($rose(nrst) |-> (!irqReq && !wdtResetReq) [*4])
        else $error("request right after reset");
    AST_WDT_PULSE: assert property (wdtResetReq |=> !wdtResetReq) else $error("reset request too long");
    AST_DRV_CAUSE: assert property (|(moduleIoDriveN & ~$past(moduleIoDriveN)) |-> $past(regWr) || $past(regWr, 2))
        else $error("drive released unasked");
    AST_OUT_QUIET: assert property (|((moduleIoOut ^ $past(moduleIoOut)) & moduleIoDriveN & $past(moduleIoDriveN))
        |-> $past(regWr) || $past(regWr, 2)) else $error("undriven output moved");
endmodule
bind prca_top prca_chk #(.MODS(MODS)) chk_u (.clk(clk), .nrst(nrst), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .moduleIoOut(moduleIoOut), .moduleIoDriveN(moduleIoDriveN), .irqReq(irqReq),
    .wdtResetReq(wdtResetReq));

/* File: testbench/programmable_counter_array_tb_top.sv */
// Purpose: Self-checking bench for the counter array
// Assumes: Partner supplies count inputs, fixed seed
// Notes:   Step counts measured over 240 cycles
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin badCount++; $display("unexpected %s exp %h got %h", n, e, g); end end
module programmable_counter_array_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [5:0] regAddr = 6'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0, regRd = 1'b0;
    logic cpuIdle = 1'b0, glitch = 1'b0;
    logic [5:0] ioLevel = 6'h00;
    logic [7:0] rdVal, rdData;
    logic [5:0] ioLine, ioOut, ioDrvN;
    logic extCount, osc8, t0Pulse, irqReq, wdtReq;
    logic [15:0] v1, v2, rnd;
    logic [7:0] capMode [3] = '{8'h20, 8'h10, 8'h30};
    int badCount = 0, checked = 0, seed = 31;
    always #5 clk = ~clk;
    prca_top dut_u (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(rdData), .cpuIdle(cpuIdle), .timer0Ovf(t0Pulse), .externalCountInput(extCount),
        .oscDiv8(osc8), .moduleIoIn(ioLine), .moduleIoOut(ioOut), .moduleIoDriveN(ioDrvN), .irqReq(irqReq),
        .wdtResetReq(wdtReq));
    prca_partner far_u (.clk(clk), .ioLevel(ioLevel), .glitch(glitch), .ioLine(ioLine), .extCount(extCount),
        .osc8(osc8), .t0Pulse(t0Pulse));
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 rdVal = rdData;
    endtask
    task automatic rd16(output logic [15:0] v);
        rd(prca_pkg::OFF_CNTL);
        v[7:0] = rdVal;
        rd(prca_pkg::OFF_CNTH);
        v[15:8] = rdVal;
    endtask
    // Partner gives ext falls every 8 cycles, timer pulses every 16
    function automatic logic [15:0] expSteps(input int c);
        int div [8] = '{12, 4, 16, 8, 1, 0, 0, 0};
        return (div[c] == 0) ? 16'h0000 : 16'(240 / div[c]);
    endfunction
    task automatic giveVerdict;
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        giveVerdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd(prca_pkg::OFF_AMODE);
        `CHK("amode", 8'h40, rdVal)
        wr(prca_pkg::OFF_CTRL, 8'h20);
        #1 `CHK("wdtforce", 1'b1, wdtReq)
        wr(prca_pkg::OFF_CNTH, 8'h55);
        rd16(v1);
        `CHK("lockedhigh", 8'h00, v1[15:8])
        rd(6'h3f);
        `CHK("unmapped", 8'h00, rdVal)
        wr(prca_pkg::OFF_AMODE, 8'h08);
        wr(prca_pkg::OFF_AMODE, 8'h08);
        wr(prca_pkg::OFF_CTRL, 8'h40);
        wr(prca_pkg::OFF_CNTH, 8'h12);
        wr(prca_pkg::OFF_CNTL, 8'hfe);
        rd16(v1);
        rd16(v2);
        `CHK("snapshot", 16'h0004, v2 - v1)
        cpuIdle <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            if (c != 5) begin
                wr(prca_pkg::OFF_AMODE, {4'h0, c[2:0], 1'b0});
                rd16(v1);
                repeat (236) @(posedge clk);
                rd16(v2);
                `CHK("steps", expSteps(c), v2 - v1)
            end
        end
        cpuIdle <= 1'b0;
        wr(prca_pkg::OFF_AMODE, 8'h09);
        wr(prca_pkg::OFF_CNTH, 8'hff);
        wr(prca_pkg::OFF_CNTL, 8'hf0);
        repeat (30) @(posedge clk);
        rd(prca_pkg::OFF_CTRL);
        `CHK("ovfflag", 1'b1, rdVal[7])
        repeat (20) @(posedge clk);
        `CHK("ovfirq", 1'b1, irqReq)
        wr(prca_pkg::OFF_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        `CHK("ovfclr", 1'b0, irqReq)
        wr(prca_pkg::OFF_CNTH, 8'h20);
        wr(prca_pkg::OFF_CNTL, 8'h00);
        wr(prca_pkg::OFF_MMODE, 8'h4d);
        wr(prca_pkg::OFF_CMPL, 8'h10);
        rd(prca_pkg::OFF_MMODE);
        `CHK("cmpoff", 8'h0d, rdVal)
        wr(prca_pkg::OFF_CMPH, 8'h20);
        rd(prca_pkg::OFF_MMODE);
        `CHK("cmpon", 8'h4d, rdVal)
        `CHK("togidle", 1'b1, ioOut[0])
        `CHK("drive", 1'b0, ioDrvN[0])
        wr(prca_pkg::OFF_CTRL, 8'h40);
        repeat (30) @(posedge clk);
        rd(prca_pkg::OFF_CTRL);
        `CHK("matchflag", 1'b1, rdVal[0])
        `CHK("toggled", 1'b0, ioOut[0])
        `CHK("matchirq", 1'b1, irqReq)
        wr(prca_pkg::OFF_CTRL, 8'h00);
        for (int k = 0; k < 3; k++) begin
            rnd = 16'($random(seed));
            wr(prca_pkg::OFF_CNTL, rnd[7:0]);
            wr(prca_pkg::OFF_CNTH, rnd[15:8]);
            wr(prca_pkg::OFF_MMODE + 6'(k + 1), capMode[k]);
            @(posedge clk);
            glitch <= 1'b1;
            @(posedge clk);
            glitch <= 1'b0;
            repeat (6) @(posedge clk);
            rd(prca_pkg::OFF_CTRL);
            `CHK("glitch", 1'b0, rdVal[k + 1])
            ioLevel <= 6'h3f;
            repeat (6) @(posedge clk);
            rd(prca_pkg::OFF_CTRL);
            `CHK("riseflag", capMode[k][5], rdVal[k + 1])
            ioLevel <= 6'h00;
            repeat (6) @(posedge clk);
            rd(prca_pkg::OFF_CTRL);
            `CHK("edgeflag", 1'b1, rdVal[k + 1])
            rd(prca_pkg::OFF_CMPL + 6'(k + 1));
            `CHK("caplow", rnd[7:0], rdVal)
            rd(prca_pkg::OFF_CMPH + 6'(k + 1));
            `CHK("caphigh", rnd[15:8], rdVal)
            wr(prca_pkg::OFF_CTRL, 8'h00);
        end
        giveVerdict();
    end
endmodule
